// ### rtl/rtcsp_params.svh
`ifndef RTCSP_PARAMS_SVH
`define RTCSP_PARAMS_SVH
// ==========================================================
// Clock and timing
`define RTCSP_CLK_MHZ 200
`define RTCSP_TWC_MS 5
// Longest write time converted exactly to whole cycles
`define RTCSP_TWC_CYC (`RTCSP_TWC_MS * 1000 * `RTCSP_CLK_MHZ)
// Watchdog pulse lengths in clock cycles (plain defaults)
`define RTCSP_WDP_SHORT 16
`define RTCSP_WDP_LONG 64
// ==========================================================
// Frame layout
`define RTCSP_BYTE_BITS 8
`define RTCSP_HDR_BITS 16
// Instruction codes that start a nonvolatile write
`define RTCSP_OP_EEWR 8'h02
`define RTCSP_OP_SRWR 8'h01
`define RTCSP_OP_IDWR 8'h32
`endif

// ### rtl/rtcsp_pkg.sv
package rtcsp_pkg;
   // ==========================================================
   // Port states, Gray coded along standby, select, program
   typedef enum logic [1:0] {
      RTCSP_STBY = 2'h0,
      RTCSP_SEL = 2'h1,
      RTCSP_PROG = 2'h3
   } rtcsp_state_t;

   // Which part of the frame a received byte belongs to
   typedef enum logic [1:0] {
      RTCSP_PH_INSTR = 2'h0,
      RTCSP_PH_ADDR = 2'h1,
      RTCSP_PH_DATA = 2'h2
   } rtcsp_phase_t;

   // Byte taken from the serial input
   typedef struct packed {
      rtcsp_phase_t phase;
      logic [7:0] data;
   } rtcsp_rxbyte_t;
endpackage : rtcsp_pkg

// ### rtl/rtcsp_port.sv
`timescale 1ns/1ps
`include "rtcsp_params.svh"
// Notes on behaviour
// - Serial clock acts only while chip select is held low; a fall in the chip select rise cycle still shifts out and pulses rdLoad.
// - Chip select high deselects and ignores clock and input; it enters standby unless it ends a valid write, which enters programming.
// - A started programming cycle always runs to completion.
// - Chip select rising during programming delays standby until done.
// - Serial output is high impedance whenever deselected.
// - Write cycle starts on the chip select rise ending a valid write.
// - Output bits change after serial clock falling edges.
// - Input bits are captured on serial clock rising edges.
// - Internal write cycle lasts at most 5 ms from select rise.
// - Watchdog overflow pulses open-drain output low, else released.
// - Watchdog pulse length chosen by configuration bit 4 of 0x0A.
// - Interrupt output pulled low on event detect or alarm.
// - Interrupt output stays low until software clears the flag.
// - All bytes travel most significant bit first.
// - Read is instruction byte, address byte, then data shifted out.
module rtcsp_port import rtcsp_pkg::*; #(
   parameter int TWC_CYCLES = `RTCSP_TWC_CYC,
   parameter int WDP_SHORT = `RTCSP_WDP_SHORT,
   parameter int WDP_LONG = `RTCSP_WDP_LONG
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic csPin_n,
   input wire logic sckPin,
   input wire logic siPin,
   output logic soOut,
   output logic soOe_n,
   output rtcsp_rxbyte_t rxByte,
   output logic rxValid,
   output logic rdLoad,
   input wire logic [7:0] rdData,
   input wire logic nvWriteEnable,
   output logic progBusy,
   output logic standby,
   input wire logic wdOverflow,
   input wire logic wdPulseLongSel,
   output logic watchdog_pulse_out,
   output logic wdOe_n,
   input wire logic eventDetect,
   input wire logic alarmHit,
   input wire logic irqFlagClear,
   output logic irqOut,
   output logic irqOe_n
);
   localparam int TWW = $clog2(TWC_CYCLES + 1);
   localparam int WDW = $clog2(WDP_LONG + 1);

   // ==========================================================
   // Pin synchronisers
   logic [2:0] csSync_r, sckSync_r, siSync_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         csSync_r <= 3'h7;
         sckSync_r <= 3'h0;
         siSync_r <= 3'h0;
      end else begin
         csSync_r <= {csSync_r[1:0], csPin_n};
         sckSync_r <= {sckSync_r[1:0], sckPin};
         siSync_r <= {siSync_r[1:0], siPin};
      end
   end

   // Edges use stages two and three only
   logic csFall, csRise, sckRise, sckFall, csLow;
   assign csLow = ~csSync_r[1];
   assign csFall = csSync_r[2] & ~csSync_r[1];
   assign csRise = ~csSync_r[2] & csSync_r[1];
   assign sckRise = ~sckSync_r[2] & sckSync_r[1];
   assign sckFall = sckSync_r[2] & ~sckSync_r[1];

   // ==========================================================
   // Port state
   rtcsp_state_t state_r;
   logic [TWW-1:0] twcCnt_r;
   logic wrValid;
   logic selected;
   assign selected = (state_r == RTCSP_SEL);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= RTCSP_STBY;
      end else begin
         case (state_r)
            RTCSP_STBY: begin
               if (csFall) begin
                  state_r <= RTCSP_SEL;
               end
            end
            RTCSP_SEL: begin
               if (csRise && wrValid) begin
                  state_r <= RTCSP_PROG;
               end else if (csRise) begin
                  state_r <= RTCSP_STBY;
               end
            end
            RTCSP_PROG: begin
               // Chip select is ignored until the cycle ends
               if (twcCnt_r == TWW'(TWC_CYCLES - 1)) begin
                  state_r <= RTCSP_STBY;
               end
            end
            default: state_r <= RTCSP_STBY;
         endcase
      end
   end

   // Write cycle timer, bounded by the longest write time
   always_ff @(posedge clk) begin
      if (sys_rst || state_r != RTCSP_PROG) begin
         twcCnt_r <= '0;
      end else begin
         twcCnt_r <= twcCnt_r + 1'b1;
      end
   end
   assign progBusy = (state_r == RTCSP_PROG);
   assign standby = (state_r == RTCSP_STBY);

   // ==========================================================
   // Receive shifter
   logic [15:0] bitCnt_r;
   logic [7:0] rxShift_r, instr_r;

   function automatic logic isNvWrite(input logic [7:0] op);
      return op == `RTCSP_OP_EEWR || op == `RTCSP_OP_SRWR ||
         op == `RTCSP_OP_IDWR;
   endfunction : isNvWrite

   // Only whole bytes past the instruction qualify as a write
   assign wrValid = isNvWrite(instr_r) && nvWriteEnable &&
      bitCnt_r[2:0] == 3'h0 && bitCnt_r >= 16'(`RTCSP_HDR_BITS);

   always_ff @(posedge clk) begin
      if (sys_rst || csFall) begin
         bitCnt_r <= '0;
         rxShift_r <= '0;
      end else if (selected && csLow && sckRise) begin
         rxShift_r <= {rxShift_r[6:0], siSync_r[2]};
         if (bitCnt_r != 16'hFFFF) begin
            bitCnt_r <= bitCnt_r + 16'h1;
         end
      end
   end

   // Byte strobe to the core, one cycle per byte
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rxValid <= 1'b0;
         rxByte <= '0;
         instr_r <= '0;
      end else begin
         rxValid <= 1'b0;
         if (selected && csLow && sckRise && bitCnt_r[2:0] == 3'h7) begin
            rxValid <= 1'b1;
            rxByte.data <= {rxShift_r[6:0], siSync_r[2]};
            if (bitCnt_r < 16'h8) begin
               rxByte.phase <= RTCSP_PH_INSTR;
               instr_r <= {rxShift_r[6:0], siSync_r[2]};
            end else if (bitCnt_r < 16'(`RTCSP_HDR_BITS)) begin
               rxByte.phase <= RTCSP_PH_ADDR;
            end else begin
               rxByte.phase <= RTCSP_PH_DATA;
            end
         end
      end
   end

   // ==========================================================
   // Transmit shifter; data follows the header bytes
   logic [7:0] txShift_r;
   logic loadNow;
   assign loadNow = selected && sckFall && bitCnt_r[2:0] == 3'h0 &&
      bitCnt_r >= 16'(`RTCSP_HDR_BITS);
   assign rdLoad = loadNow;

   always_ff @(posedge clk) begin
      if (sys_rst || csFall) begin
         txShift_r <= '0;
         soOut <= 1'b0;
      end else if (loadNow) begin
         txShift_r <= {rdData[6:0], 1'b0};
         soOut <= rdData[7];
      end else if (selected && sckFall) begin
         txShift_r <= {txShift_r[6:0], 1'b0};
         soOut <= txShift_r[7];
      end
   end

   // Driver only while selected; released at once on deselect
   assign soOe_n = ~(selected && csLow);

   // ==========================================================
   // Watchdog pulse; a second overflow restarts the pulse
   logic [WDW-1:0] wdCnt_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wdCnt_r <= '0;
      end else if (wdOverflow) begin
         wdCnt_r <= wdPulseLongSel ? WDW'(WDP_LONG) :
            WDW'(WDP_SHORT);
      end else if (wdCnt_r != '0) begin
         wdCnt_r <= wdCnt_r - 1'b1;
      end
   end
   assign watchdog_pulse_out = 1'b0;
   assign wdOe_n = (wdCnt_r == '0);

   // ==========================================================
   // Interrupt flag; a set in the clear cycle wins
   logic irqFlag_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irqFlag_r <= 1'b0;
      end else if (eventDetect || alarmHit) begin
         irqFlag_r <= 1'b1;
      end else if (irqFlagClear) begin
         irqFlag_r <= 1'b0;
      end
   end
   assign irqOut = 1'b0;
   assign irqOe_n = ~irqFlag_r;

   // ==========================================================
   // Checks
   sequence s_wrEnd;
      selected && csRise && wrValid;
   endsequence
   sequence s_progRun;
      progBusy [*8];
   endsequence

   a_sel_only_low: assert property (@(posedge clk) disable iff (sys_rst)
      rxValid |-> $past(csLow)) else $error("byte taken while high");
   a_desel_stby: assert property (@(posedge clk) disable iff (sys_rst)
      selected && csRise && !wrValid |=> standby)
      else $error("no standby on deselect");
   a_prog_hold: assert property (@(posedge clk) disable iff (sys_rst)
      s_wrEnd |=> s_progRun)
      else $error("write cycle cut short");
   a_so_hiz: assert property (@(posedge clk) disable iff (sys_rst)
      !selected |-> soOe_n) else $error("output driven deselected");
   a_wr_start: assert property (@(posedge clk) disable iff (sys_rst)
      s_wrEnd |=> progBusy && twcCnt_r == '0)
      else $error("write not started");
   a_so_fall: assert property (@(posedge clk) disable iff (sys_rst)
      $changed(soOut) && !$past(csFall) |-> $past(sckFall))
      else $error("output moved off falling edge");
   a_twc_max: assert property (@(posedge clk) disable iff (sys_rst)
      progBusy |-> twcCnt_r < TWW'(TWC_CYCLES))
      else $error("write cycle too long");
   a_wd_pulse: assert property (@(posedge clk) disable iff (sys_rst)
      wdOverflow && !wdPulseLongSel |=> !wdOe_n [*8])
      else $error("watchdog pulse missing");
   a_irq_hold: assert property (@(posedge clk) disable iff (sys_rst)
      !irqOe_n && !irqFlagClear |=> !irqOe_n)
      else $error("interrupt dropped early");
   a_irq_set: assert property (@(posedge clk) disable iff (sys_rst)
      alarmHit || eventDetect |=> !irqOe_n)
      else $error("interrupt not raised");
   a_cnt_reset: assert property (@(posedge clk) disable iff (sys_rst)
      csFall |=> bitCnt_r == '0) else $error("counter not cleared");
endmodule : rtcsp_port

// ### tb/rtcsp_spi_master.sv
`timescale 1ns/1ps
// ==========================================================
// Host master, mode 0; clock idles low outside its shifts
module rtcsp_spi_master (
   output logic csPin_n,
   output logic sckPin,
   output logic siPin,
   input wire logic soLine
);
   // Idle levels; deselected until the first frame
   initial begin
      csPin_n = 1'b1;
      sckPin = 1'b0;
      siPin = 1'b0;
   end
   // Select edge with setup and hold around the clock
   task automatic select(input logic lvl);
      #32 csPin_n = lvl;
      siPin = ~siPin; // Input wanders outside the bits
      #32;
   endtask : select
   // Bits go out MSB first, each set up before its rise
   task automatic shift(input logic [7:0] txd, input int nbits,
                        output logic [7:0] rxd);
      rxd = 8'h00;
      for (int i = 7; i > 7 - nbits; i--) begin
         siPin = txd[i];
         #32 sckPin = 1'b1;
         rxd = {rxd[6:0], soLine};
         #32 sckPin = 1'b0;
      end
   endtask : shift
endmodule : rtcsp_spi_master

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench import rtcsp_pkg::*;;
   localparam int TWC = 200;
   logic clk, sys_rst, csPin_n, sckPin, siPin, soOut, soOe_n, rxValid;
   logic rdLoad, progBusy, standby, wdPin, wdOe_n, irqPin, irqOe_n;
   logic nvWriteEnable, wdOverflow, wdPulseLongSel;
   logic eventDetect, alarmHit, irqFlagClear;
   logic [7:0] rdData, a, d, r;
   logic [7:0] ops[3] = '{8'h02, 8'h01, 8'h32};
   rtcsp_rxbyte_t rxByte;
   rtcsp_rxbyte_t rxq[$];
   int fail_count = 0;
   int comparisons = 0;
   int n, w, g, l0;
   int loads = 0;
   logic en;
   logic [1:0] src;
   wire soLine = soOe_n ? 1'bz : soOut;
   // ==========================================================
   // Design and far-side master
   rtcsp_port #(.TWC_CYCLES(TWC))
   u_rtcsp_port (.clk(clk), .sys_rst(sys_rst), .csPin_n(csPin_n),
      .sckPin(sckPin), .siPin(siPin), .soOut(soOut), .soOe_n(soOe_n),
      .rxByte(rxByte), .rxValid(rxValid), .rdLoad(rdLoad),
      .rdData(rdData), .nvWriteEnable(nvWriteEnable),
      .progBusy(progBusy), .standby(standby), .wdOverflow(wdOverflow),
      .wdPulseLongSel(wdPulseLongSel), .watchdog_pulse_out(wdPin),
      .wdOe_n(wdOe_n), .eventDetect(eventDetect), .alarmHit(alarmHit),
      .irqFlagClear(irqFlagClear), .irqOut(irqPin), .irqOe_n(irqOe_n));
   rtcsp_spi_master u_rtcsp_spi_master (.csPin_n(csPin_n),
      .sckPin(sckPin), .siPin(siPin), .soLine(soLine));
   // ==========================================================
   // Clock, byte monitor off the sampling edge, hang guard
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(negedge clk) begin
      if (rxValid === 1'b1) rxq.push_back(rxByte);
      if (rdLoad === 1'b1) loads++;
   end
   initial begin
      #200000;
      fail_count++;
      test_done();
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   task automatic test_done;
      $display("checks %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : test_done
   // ==========================================================
   // Main sequence
   initial begin
      {sys_rst, nvWriteEnable, wdOverflow, wdPulseLongSel} = 4'h8;
      {eventDetect, alarmHit, irqFlagClear, rdData} = 11'h000;
      void'($urandom(32'h6C0C));
      tick(5);
      sys_rst = 1'b0;
      check("idle pins", {standby, progBusy, soOe_n, wdOe_n, irqOe_n},
            5'h17);
      u_rtcsp_spi_master.select(1'b0);
      u_rtcsp_spi_master.select(1'b1);
      // Partial byte, clock while deselected, then a full read
      for (int k = 0; k < 3; k++) begin
         tick(1);
         rdData = 8'($urandom);
         l0 = loads;
         a = 8'($urandom);
         rxq = {};
         u_rtcsp_spi_master.select(1'b0);
         u_rtcsp_spi_master.shift(8'h03, 1 + $urandom % 7, r);
         u_rtcsp_spi_master.select(1'b1);
         u_rtcsp_spi_master.shift(8'h03, 8, r);
         check("stray bytes", rxq.size(), 0);
         u_rtcsp_spi_master.select(1'b0);
         check("standby sel", standby, 0);
         u_rtcsp_spi_master.shift(8'h03, 8, r);
         u_rtcsp_spi_master.shift(a, 8, r);
         u_rtcsp_spi_master.shift(8'hFF, 8, r);
         check("read byte", r, rdData);
         u_rtcsp_spi_master.select(1'b1);
         check("so release", {soOe_n, standby}, 2'h3);
         // One load per data byte, plus one at the final fall
         check("read loads", loads - l0, 2);
         check("instr", rxq[0], {RTCSP_PH_INSTR, 8'h03});
         check("addr", rxq[1], {RTCSP_PH_ADDR, a});
      end
      // Write per opcode, last one without write enable
      for (int i = 0; i < 4; i++) begin
         en = (i < 3);
         tick(1);
         nvWriteEnable = en;
         {a, d} = 16'($urandom);
         rxq = {};
         u_rtcsp_spi_master.select(1'b0);
         u_rtcsp_spi_master.shift(ops[i % 3], 8, r);
         u_rtcsp_spi_master.shift(a, 8, r);
         u_rtcsp_spi_master.shift(d, 8, r);
         n = 0;
         fork
            begin
               u_rtcsp_spi_master.select(1'b1);
               u_rtcsp_spi_master.select(1'b0);
               check("busy low cs", progBusy, en);
               u_rtcsp_spi_master.shift(8'h03, 8, r);
               u_rtcsp_spi_master.select(1'b1);
               check("standby prog", standby, !en);
            end
            begin
               for (w = 0; w < 20 && progBusy !== 1'b1; w++) tick(1);
               while (progBusy === 1'b1 && n < TWC + 9) begin
                  n++;
                  tick(1);
               end
            end
         join
         check("write time", n, en ? TWC : 0);
         check("standby end", standby, 1);
         check("data", rxq[2], {RTCSP_PH_DATA, d});
         check("bytes", rxq.size(), en ? 3 : 4);
      end
      // Watchdog pulse for both lengths, then each retriggered
      for (int i = 0; i < 4; i++) begin
         wdPulseLongSel = i[0];
         g = i[1] ? 2 + $urandom % 10 : 999;
         wdOverflow = 1'b1;
         tick(1);
         for (w = 0; w < 3 && wdOe_n !== 1'b0; w++) tick(1);
         for (n = 0; wdOe_n === 1'b0 && n < 199; n++) begin
            wdOverflow = (n == g); // Second overflow mid-pulse
            tick(1);
         end
         wdOverflow = 1'b0;
         // A retrigger reloads the full length at its own edge
         w = (i[0] ? 64 : 16) + (i[1] ? g + 1 : 0);
         check("wd pulse", n, w);
         check("wd level", wdPin, 0);
      end
      // Interrupt from each source and both, held until cleared
      for (int i = 0; i < 3; i++) begin
         src = 2'(i + 1);
         {eventDetect, alarmHit} = src;
         tick(1);
         {eventDetect, alarmHit} = 2'h0;
         tick(2 + $urandom % 20);
         check("irq held", {irqOe_n, irqPin}, 2'h0);
         // A new event in the clearing cycle keeps the flag up
         {eventDetect, alarmHit} = src;
         irqFlagClear = 1'b1;
         tick(1);
         {eventDetect, alarmHit} = 2'h0;
         check("irq set wins", irqOe_n, 0);
         tick(1);
         irqFlagClear = 1'b0;
         tick(2);
         check("irq clear", irqOe_n, 1);
      end
      test_done();
   end
endmodule : testbench
